//--- hdl/afc_seq_fabric.v
// Fabric-control mode of the converter scan sequencer with its register port.
`timescale 1ns/1ps
`include "afc_consts.vh"

module afc_seq_fabric (
    input wire core_clk,
    input wire arst_n,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire [7:0] fab_pin_route,
    input wire [3:0] fab_bus_route,
    input wire [1:0] fab_aux_sw,
    input wire fab_vref_neg,
    input wire [1:0] fab_sample_sel,
    input wire fab_average,
    input wire fab_resolution,
    input wire fab_differential,
    input wire fab_trigger,
    input wire fab_hilo_sel,
    output reg fab_sample_done_q,
    output reg fab_tag_valid_q,
    output reg [3:0] fab_tag_q,
    output reg fab_data_valid_q,
    output wire [11:0] fab_data,
    output reg fab_eos_q,
    output reg [7:0] sw_pin_q,
    output reg [3:0] sw_bus_q,
    output reg sw_gnd_neg_q,
    output reg sw_temp_pos_q,
    output reg sw_vref_neg_q,
    output reg conv_start_q,
    output reg [7:0] conv_sample_cycles_q,
    output reg [1:0] conv_res_q,
    output reg conv_diff_q,
    input wire conv_sample_end,
    input wire conv_done,
    input wire [11:0] conv_raw
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_CONV = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [31:0] ctrl_q;
    reg [31:0] sample_t_q;
    reg [31:0] global_q;
    reg [13:0] mux_fw_q;
    reg [13:0] mux_hw_q;
    reg [31:0] range_q;
    reg [2:0] intr_q;
    reg [15:0] work0_q;
    reg [15:0] result0_q;
    reg [1:0] state_q;
    reg [1:0] cfg_st_q;
    reg cfg_avg_q;
    reg cfg_res_q;
    reg cfg_diff_q;
    reg [4:0] cnt_q;
    reg [15:0] acc_q;
    reg sat_q;
    reg [15:0] out_data_q;
    reg [1:0] hold_q;
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg done_pend_q;
    reg range_hit_q;

    wire fabric_mode = ctrl_q[`AFC_CTRL_FABRIC];
    wire [2:0] neg_sel = ctrl_q[`AFC_CTRL_NEGSEL_HI:`AFC_CTRL_NEGSEL_LO];
    wire wr_ctrl = reg_wr && (reg_addr == `AFC_REG_CTRL);
    wire wr_intr = reg_wr && (reg_addr == `AFC_REG_INTR);

    // ****************************************************************
    // Configuration input path
    // ****************************************************************
    // optional two-flop sync
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {fab_sample_sel, fab_average, fab_resolution, fab_differential};
            sync2_q <= sync1_q;
        end
    end

    // Bypass exists because at very slow converter rates the sync delay can miss a trigger-aligned setting.
    wire [4:0] cfg_in = ctrl_q[`AFC_CTRL_SYNC] ? sync2_q :
        {fab_sample_sel, fab_average, fab_resolution, fab_differential};

    // ****************************************************************
    // Trigger sources
    // ****************************************************************
    // fabric, firmware, continuous
    wire trig_any = fabric_mode && (fab_trigger || ctrl_q[`AFC_CTRL_FWTRIG] || ctrl_q[`AFC_CTRL_CONT]);

    // ****************************************************************
    // Averaging and result checks
    // ****************************************************************
    wire [4:0] avg_total = cfg_avg_q ? (5'h02 << global_q[1:0]) : 5'h01;
    reg [11:0] res_max;
    always @* begin
        res_max = 12'hFFF;
        if (cfg_res_q) begin
            res_max = global_q[2] ? 12'h0FF : 12'h3FF;
        end
    end
    wire [15:0] acc_next = acc_q + {4'h0, conv_raw};
    wire raw_sat = (conv_raw == 12'h000) || (conv_raw >= res_max);
    wire last_sample = (cnt_q + 5'h01) >= avg_total;
    wire [15:0] final_res = acc_next;
    wire range_hit = (final_res < range_q[15:0]) || (final_res > range_q[31:16]);

    // ****************************************************************
    // Conversion sequence
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            cfg_st_q <= 2'h0;
            cfg_avg_q <= 1'b0;
            cfg_res_q <= 1'b0;
            cfg_diff_q <= 1'b0;
            cnt_q <= 5'h00;
            acc_q <= 16'h0000;
            sat_q <= 1'b0;
            conv_start_q <= 1'b0;
            fab_sample_done_q <= 1'b0;
            done_pend_q <= 1'b0;
            out_data_q <= 16'h0000;
            work0_q <= 16'h0000;
            result0_q <= 16'h0000;
        end else begin
            conv_start_q <= 1'b0;
            fab_sample_done_q <= 1'b0;
            done_pend_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (trig_any) begin
                        {cfg_st_q, cfg_avg_q, cfg_res_q, cfg_diff_q} <= cfg_in;
                        cnt_q <= 5'h00;
                        acc_q <= 16'h0000;
                        sat_q <= 1'b0;
                        conv_start_q <= 1'b1;
                        state_q <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (conv_sample_end) begin
                        fab_sample_done_q <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        acc_q <= acc_next;
                        sat_q <= sat_q | raw_sat;
                        cnt_q <= cnt_q + 5'h01;
                        if (last_sample) begin
                            work0_q <= final_res;
                            result0_q <= final_res;
                            out_data_q <= final_res;
                            done_pend_q <= 1'b1;
                            state_q <= ST_DONE;
                        end else begin
                            conv_start_q <= 1'b1;
                            state_q <= ST_SAMPLE;
                        end
                    end
                end
                ST_DONE: begin
                    if (hold_q == 2'h0 && !done_pend_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Result export towards the fabric
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= 2'h0;
            fab_data_valid_q <= 1'b0;
            fab_tag_valid_q <= 1'b0;
            fab_tag_q <= 4'h0;
            fab_eos_q <= 1'b0;
        end else begin
            if (done_pend_q) begin
                hold_q <= `AFC_HOLD_CYCLES - 2'h1;
                fab_data_valid_q <= 1'b1;
                fab_tag_valid_q <= 1'b1;
                fab_tag_q <= {2'h0, range_hit_q, sat_q};
                fab_eos_q <= 1'b1;
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end else begin
                fab_data_valid_q <= 1'b0;
                fab_tag_valid_q <= 1'b0;
                fab_eos_q <= 1'b0;
            end
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            range_hit_q <= 1'b0;
        end else if (state_q == ST_CONV && conv_done && last_sample) begin
            range_hit_q <= range_hit;
        end
    end

    assign fab_data = fab_hilo_sel ? {4'h0, out_data_q[15:8]} : out_data_q[11:0];

    // ****************************************************************
    // Converter settings
    // ****************************************************************
    // Settings are taken at the trigger edge so that they stand beside the first start pulse.
    wire cfg_take = (state_q == ST_IDLE) && trig_any;
    wire [4:0] cfg_use = cfg_take ? cfg_in : {cfg_st_q, cfg_avg_q, cfg_res_q, cfg_diff_q};
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_sample_cycles_q <= 8'h00;
            conv_res_q <= 2'h0;
            conv_diff_q <= 1'b0;
        end else begin
            case (cfg_use[4:3])
                2'h0: conv_sample_cycles_q <= sample_t_q[7:0];
                2'h1: conv_sample_cycles_q <= sample_t_q[15:8];
                2'h2: conv_sample_cycles_q <= sample_t_q[23:16];
                default: conv_sample_cycles_q <= sample_t_q[31:24];
            endcase
            conv_res_q <= cfg_use[1] ? (global_q[2] ? 2'h2 : 2'h1) : 2'h0;
            conv_diff_q <= cfg_use[0];
        end
    end

    // ****************************************************************
    // Analog switch enables
    // ****************************************************************
    // owned switches need both bits
    wire [13:0] fab_req = {fab_aux_sw[1], fab_aux_sw[0], fab_bus_route, fab_pin_route};
    wire [13:0] sw_next;
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi = gi + 1) begin : g_sw
            assign sw_next[gi] = (fabric_mode && mux_hw_q[gi]) ? (mux_fw_q[gi] && fab_req[gi]) : mux_fw_q[gi];
        end
    endgenerate

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_pin_q <= 8'h00;
            sw_bus_q <= 4'h0;
            sw_gnd_neg_q <= 1'b0;
            sw_temp_pos_q <= 1'b0;
            sw_vref_neg_q <= 1'b0;
        end else begin
            sw_pin_q <= sw_next[7:0];
            sw_bus_q <= sw_next[11:8];
            sw_temp_pos_q <= sw_next[`AFC_MUX_TEMP];
            // Steering follows the live differential input, because switches are set before the trigger.
            // single-ended negative steering
            sw_gnd_neg_q <= sw_next[`AFC_MUX_GND] && !(fabric_mode && fab_differential);
            sw_vref_neg_q <= fabric_mode && !fab_differential && (neg_sel == `AFC_NEGSEL_VREF) &&
                ctrl_q[`AFC_CTRL_NEGHW] && fab_vref_neg;
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    wire eos_evt = done_pend_q;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `AFC_CTRL_RST;
            sample_t_q <= `AFC_SAMPLE_T_RST;
            global_q <= `AFC_GLOBAL_RST;
            mux_fw_q <= 14'h0000;
            mux_hw_q <= 14'h0000;
            range_q <= `AFC_RANGE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata;
            end else if (trig_any && state_q == ST_IDLE) begin
                // Firmware trigger is self-clearing once taken.
                ctrl_q[`AFC_CTRL_FWTRIG] <= 1'b0;
            end
            if (reg_wr && reg_addr == `AFC_REG_SAMPLE_T) begin
                sample_t_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `AFC_REG_GLOBAL) begin
                global_q <= {29'h0000_0000, reg_wdata[2:0]};
            end
            if (reg_wr && reg_addr == `AFC_REG_MUX_FW) begin
                mux_fw_q <= reg_wdata[13:0];
            end
            if (reg_wr && reg_addr == `AFC_REG_MUX_HW) begin
                mux_hw_q <= reg_wdata[13:0];
            end
            if (reg_wr && reg_addr == `AFC_REG_RANGE) begin
                range_q <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            intr_q <= 3'h0;
        end else begin
            intr_q[`AFC_INT_SAT] <= (eos_evt && sat_q) ||
                (intr_q[`AFC_INT_SAT] && !(wr_intr && reg_wdata[`AFC_INT_SAT]));
            intr_q[`AFC_INT_RANGE] <= (eos_evt && range_hit_q) ||
                (intr_q[`AFC_INT_RANGE] && !(wr_intr && reg_wdata[`AFC_INT_RANGE]));
            intr_q[`AFC_INT_EOS] <= eos_evt ||
                (intr_q[`AFC_INT_EOS] && !(wr_intr && reg_wdata[`AFC_INT_EOS]));
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `AFC_REG_CTRL: reg_rdata_q <= ctrl_q;
                `AFC_REG_SAMPLE_T: reg_rdata_q <= sample_t_q;
                `AFC_REG_GLOBAL: reg_rdata_q <= global_q;
                `AFC_REG_MUX_FW: reg_rdata_q <= {18'h0_0000, mux_fw_q};
                `AFC_REG_MUX_HW: reg_rdata_q <= {18'h0_0000, mux_hw_q};
                `AFC_REG_RANGE: reg_rdata_q <= range_q;
                `AFC_REG_INTR: reg_rdata_q <= {27'h000_0000, state_q, intr_q};
                `AFC_REG_WORK0: reg_rdata_q <= {16'h0000, work0_q};
                `AFC_REG_RESULT0: reg_rdata_q <= {16'h0000, result0_q};
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

endmodule

//--- shared/afc_consts.vh
// Constants for the fabric-controlled converter sequencer block.
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH
// Register word indexes.
`define AFC_REG_CTRL 4'h0
`define AFC_REG_SAMPLE_T 4'h1
`define AFC_REG_GLOBAL 4'h2
`define AFC_REG_MUX_FW 4'h3
`define AFC_REG_MUX_HW 4'h4
`define AFC_REG_RANGE 4'h5
`define AFC_REG_INTR 4'h6
`define AFC_REG_WORK0 4'h7
`define AFC_REG_RESULT0 4'h8
// Control register fields.
`define AFC_CTRL_FABRIC 0
`define AFC_CTRL_SYNC 1
`define AFC_CTRL_CONT 2
`define AFC_CTRL_FWTRIG 3
`define AFC_CTRL_NEGSEL_LO 9
`define AFC_CTRL_NEGSEL_HI 11
`define AFC_CTRL_NEGHW 13
`define AFC_NEGSEL_VREF 3'h7
// Mux switch register layout.
`define AFC_MUX_GND 12
`define AFC_MUX_TEMP 13
// Interrupt status bits.
`define AFC_INT_SAT 0
`define AFC_INT_RANGE 1
`define AFC_INT_EOS 2
// Reset values.
`define AFC_CTRL_RST 32'h0000_0000
`define AFC_SAMPLE_T_RST 32'h0404_0404
`define AFC_GLOBAL_RST 32'h0000_0000
`define AFC_RANGE_RST 32'hFFFF_0000
// Result strobe hold, in system clock cycles.
`define AFC_HOLD_CYCLES 2'h2
`endif

//--- testbench/afc_conv_model.sv
// Behavioural converter that answers the sequencer's start pulses.
`timescale 1ns/1ps
module afc_conv_model (
    input wire core_clk,
    input wire conv_start_q,
    input wire [11:0] raw_in,
    input wire [3:0] lag,
    output logic conv_sample_end,
    output logic conv_done,
    output logic [11:0] conv_raw
);
    // ********************
    // Conversion timing
    // ********************
    initial begin
        conv_sample_end = 1'b0;
        conv_done = 1'b0;
        conv_raw = 12'h000;
        forever begin
            @(posedge core_clk);
            if (conv_start_q) begin
                repeat (lag) @(posedge core_clk);
                conv_sample_end <= 1'b1;
                @(posedge core_clk);
                conv_sample_end <= 1'b0;
                repeat (lag + 1) @(posedge core_clk);
                conv_done <= 1'b1;
                conv_raw <= raw_in;
                @(posedge core_clk);
                conv_done <= 1'b0;
                // Stale data is inverted so that a late capture cannot pass.
                conv_raw <= ~raw_in;
            end
        end
    end
endmodule

//--- testbench/afc_seq_fabric_assertions.sv
// Port-level checks for the fabric-mode sequencer.
`timescale 1ns/1ps
module afc_seq_fabric_assertions (
    input wire core_clk,
    input wire arst_n,
    input wire fab_hilo_sel,
    input wire fab_sample_done_q,
    input wire fab_tag_valid_q,
    input wire [3:0] fab_tag_q,
    input wire fab_data_valid_q,
    input wire [11:0] fab_data,
    input wire fab_eos_q,
    input wire conv_start_q,
    input wire conv_sample_end,
    input wire conv_done
);
    // ********************
    // Checks
    // ********************
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    a_eos_copy: assert property (fab_eos_q == fab_data_valid_q)
        else $error("eos differs from data valid");
    a_tag_valid: assert property (fab_tag_valid_q == fab_data_valid_q)
        else $error("tag valid differs from data valid");
    a_hold_two: assert property ($rose(fab_data_valid_q) |=> fab_data_valid_q ##1 !fab_data_valid_q)
        else $error("data valid not two cycles");
    a_export_lag: assert property ($rose(fab_data_valid_q) |-> $past(conv_done, 2))
        else $error("result not two edges after done");
    a_tag_kept: assert property (fab_tag_valid_q |=> $stable(fab_tag_q))
        else $error("tag changed while valid");
    a_done_pulse: assert property (conv_sample_end |=> fab_sample_done_q)
        else $error("sample done missing");
    a_done_cause: assert property (fab_sample_done_q |-> $past(conv_sample_end))
        else $error("sample done without sampling end");
    a_hilo_upper: assert property (fab_hilo_sel |-> fab_data[11:8] == 4'h0)
        else $error("upper nibble not zero");
    a_tag_upper: assert property (fab_tag_q[3:2] == 2'h0)
        else $error("tag upper bits set");
    a_busy_start: assert property (fab_data_valid_q |-> !conv_start_q)
        else $error("start during result hold");
    c_sat: cover property ($rose(fab_data_valid_q) && fab_tag_q[0]);
    c_hilo: cover property ($rose(fab_data_valid_q) ##1 fab_hilo_sel);
    c_sample: cover property (fab_sample_done_q);
endmodule

//--- testbench/tb_adc_sequencer_fabric_control_mode.sv
// Self-checking bench for the fabric-mode converter sequencer.
`timescale 1ns/1ps
`include "afc_consts.vh"
module tb_adc_sequencer_fabric_control_mode;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic vprev = 1'b0;
    logic [7:0] fab_pin_route = 8'h00;
    logic [3:0] fab_bus_route = 4'h0;
    logic [1:0] fab_aux_sw = 2'h0;
    logic [1:0] fab_sample_sel = 2'h0;
    logic fab_vref_neg = 1'b0;
    logic fab_average = 1'b0;
    logic fab_resolution = 1'b0;
    logic fab_differential = 1'b0;
    logic fab_trigger = 1'b0;
    logic fab_hilo_sel = 1'b0;
    logic [11:0] raw_in = 12'h000;
    logic [3:0] lag = 4'h0;
    logic [31:0] seed = 32'hed20_186d;
    logic [31:0] ctrl = 32'h0000_0000;
    logic [31:0] reg_rdata_q;
    logic fab_sample_done_q, fab_tag_valid_q, fab_data_valid_q, fab_eos_q;
    logic [3:0] fab_tag_q;
    logic [11:0] fab_data;
    logic [7:0] sw_pin_q;
    logic [3:0] sw_bus_q;
    logic sw_gnd_neg_q, sw_temp_pos_q, sw_vref_neg_q, conv_start_q, conv_diff_q;
    logic [7:0] conv_sample_cycles_q;
    logic [1:0] conv_res_q;
    logic conv_sample_end, conv_done;
    logic [11:0] conv_raw;
    logic [31:0] rq[$];
    logic [17:0] eq[$];
    int n_fail = 0;
    int samples_checked = 0;

    afc_seq_fabric DUT (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .fab_pin_route, .fab_bus_route, .fab_aux_sw, .fab_vref_neg, .fab_sample_sel, .fab_average,
        .fab_resolution, .fab_differential, .fab_trigger, .fab_hilo_sel, .fab_sample_done_q,
        .fab_tag_valid_q, .fab_tag_q, .fab_data_valid_q, .fab_data, .fab_eos_q, .sw_pin_q, .sw_bus_q,
        .sw_gnd_neg_q, .sw_temp_pos_q, .sw_vref_neg_q, .conv_start_q, .conv_sample_cycles_q,
        .conv_res_q, .conv_diff_q, .conv_sample_end, .conv_done, .conv_raw);
    afc_conv_model u_conv (.core_clk, .conv_start_q, .raw_in, .lag, .conv_sample_end, .conv_done, .conv_raw);

    always #2 core_clk = ~core_clk;

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic swchk(input logic fm);
        logic [13:0] e;
        seed = xs(seed);
        fab_pin_route <= seed[7:0];
        fab_bus_route <= seed[11:8];
        fab_aux_sw <= seed[13:12];
        fab_vref_neg <= seed[14];
        fab_differential <= seed[15];
        e = fm ? {seed[13], seed[12] & !seed[15], seed[11:0]} : 14'h3FFF;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check("switches", {18'h0, e}, {18'h0, sw_temp_pos_q, sw_gnd_neg_q, sw_bus_q, sw_pin_q});
        check("vref", {31'h0, fm & seed[14] & !seed[15]}, {31'h0, sw_vref_neg_q});
    endtask

    // How: 0 fabric trigger, 1 firmware trigger, 2 continuous for three results.
    task automatic conv(input logic [1:0] how, input logic avg, input logic [2:0] g);
        logic [31:0] r;
        logic [11:0] m;
        logic [11:0] raw;
        logic [15:0] sum;
        logic [1:0] tg;
        int n;
        int st;
        int nr;
        int got;
        logic vp;
        seed = xs(seed);
        r = seed;
        m = !r[2] ? 12'hFFF : (g[2] ? 12'h0FF : 12'h3FF);
        raw = (r[5:4] == 2'h0) ? m : r[27:16] & m;
        n = avg ? 2 << g[1:0] : 1;
        nr = (how == 2'h2) ? 3 : 1;
        sum = 16'(raw * n);
        tg = {sum < 16'h0100 || sum > 16'h0800, raw == 12'h000 || raw == m};
        wr(`AFC_REG_GLOBAL, {29'h0, g});
        wr(`AFC_REG_CTRL, ctrl);
        fab_sample_sel <= r[1:0];
        fab_resolution <= r[2];
        fab_differential <= r[3];
        fab_average <= avg;
        raw_in <= raw;
        lag <= r[9:6];
        repeat (nr) eq.push_back({tg, sum});
        repeat (3) @(posedge core_clk);
        if (how == 2'h0)
            fab_trigger <= 1'b1;
        else
            wr(`AFC_REG_CTRL, ctrl | (how == 2'h1 ? 32'h0000_0008 : 32'h0000_0004));
        st = 0;
        got = 0;
        vp = 1'b0;
        for (int k = 0; k < 3000 && got < nr; k++) begin
            @(negedge core_clk);
            if (conv_start_q && st == 0) begin
                check("cycles", {27'h0, r[1:0], 3'h7}, {24'h0, conv_sample_cycles_q});
                check("res", {30'h0, r[2] ? (g[2] ? 2'h2 : 2'h1) : 2'h0}, {30'h0, conv_res_q});
                check("diff", {31'h0, r[3]}, {31'h0, conv_diff_q});
            end
            st += int'(conv_start_q);
            got += int'(fab_data_valid_q && !vp);
            vp = fab_data_valid_q;
        end
        if (how == 2'h2) begin
            wr(`AFC_REG_CTRL, ctrl);
        end else begin
            @(posedge core_clk);
            fab_trigger <= 1'b0;
        end
        if (got < nr) begin
            check("wait", 32'h0, 32'h1);
            wrap_up();
        end
        check("starts", n * nr, st);
        repeat (3) @(posedge core_clk);
        rd(`AFC_REG_WORK0, {16'h0, sum});
        rd(`AFC_REG_RESULT0, {16'h0, sum});
        rd(`AFC_REG_INTR, {29'h0, 1'b1, tg});
        wr(`AFC_REG_INTR, 32'h0000_0007);
    endtask

    // ********************
    // Monitors
    // ********************
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk) if (rd_d) check("rdata", rq.pop_front(), reg_rdata_q);

    // The high byte is read in the second valid cycle, while the result still stands.
    initial begin : mon
        logic [17:0] e;
        forever begin
            @(negedge core_clk);
            if (fab_data_valid_q && !vprev) begin
                check("queued", 32'h1, {31'h0, eq.size() != 0});
                e = eq.pop_front();
                check("data_lo", {20'h0, e[11:0]}, {20'h0, fab_data});
                check("tag", {30'h0, e[17:16]}, {28'h0, fab_tag_q});
                @(posedge core_clk);
                fab_hilo_sel <= 1'b1;
                @(negedge core_clk);
                check("data_hi", {24'h0, e[15:8]}, {20'h0, fab_data});
                @(posedge core_clk);
                fab_hilo_sel <= 1'b0;
            end
            vprev = fab_data_valid_q;
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`AFC_REG_CTRL, `AFC_CTRL_RST);
        rd(`AFC_REG_SAMPLE_T, `AFC_SAMPLE_T_RST);
        rd(`AFC_REG_RANGE, `AFC_RANGE_RST);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF, 32'h0000_0000);
        wr(`AFC_REG_SAMPLE_T, 32'h1F17_0F07);
        wr(`AFC_REG_RANGE, 32'h0800_0100);
        wr(`AFC_REG_MUX_FW, 32'h0000_3FFF);
        wr(`AFC_REG_MUX_HW, 32'h0000_3FFF);
        repeat (3) swchk(1'b0);
        ctrl = 32'h0000_2E01;
        wr(`AFC_REG_CTRL, ctrl);
        repeat (6) swchk(1'b1);
        for (int i = 0; i < 12; i++) begin
            ctrl = {30'h0, i[1], 1'b0} | 32'h0000_2E01;
            conv(2'(i % 3), i >= 8, 3'(i));
        end
        repeat (20) @(posedge core_clk);
        wrap_up();
    end
endmodule

bind afc_seq_fabric afc_seq_fabric_assertions u_chk (.core_clk, .arst_n, .fab_hilo_sel,
    .fab_sample_done_q, .fab_tag_valid_q, .fab_tag_q, .fab_data_valid_q, .fab_data, .fab_eos_q,
    .conv_start_q, .conv_sample_end, .conv_done);
